//--- design/psc_pkg.sv
package psc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int INT_PERIOD_NS  = 1900000;
  localparam int SCAN_NS        = 600000;
  localparam int STATUS_NS      = 150000;
  localparam int GROUP_NS       = 450000;
  localparam int MEM_ACCESS_NS  = 10000;
  localparam int TRIG_WIDTH_NS  = 10000;
  localparam int INT_PERIOD_CYC = INT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SCAN_CYC       = SCAN_NS / CLK_PERIOD_NS;
  localparam int STATUS_CYC     =
    (STATUS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GROUP_CYC      = GROUP_NS / CLK_PERIOD_NS;
  localparam int MEM_ACCESS_CYC =
    (MEM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_WIDTH_CYC =
    (TRIG_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_STEP_PERIOD = 8'h00;
  localparam logic [7:0] REG_INSTR       = 8'h04;
  localparam logic [7:0] REG_MEM_ADDR    = 8'h08;
  localparam logic [7:0] REG_MEM_CMD     = 8'h0C;
  localparam logic [7:0] REG_MEM_STAT    = 8'h10;
  localparam logic [7:0] REG_PANEL       = 8'h14;
  localparam logic [7:0] REG_STEP_SW     = 8'h18;
  localparam logic [7:0] REG_RET_SW      = 8'h1C;
  localparam logic [7:0] REG_LAMPS       = 8'h20;
  // ==========================================================
  // fields and reset values
  localparam int          CMD_GO_BIT      = 0;
  localparam int          CMD_WRITE_BIT   = 1;
  localparam int          DATA_LSB        = 4;
  localparam int          BANK_SEL_LSB    = 2;
  localparam logic [31:0] STEP_PERIOD_RST = 32'h0001_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : psc_pkg

//--- design/psc_axil.sv
`timescale 1ns/1ps
`default_nettype none
module psc_axil (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  import psc_pkg::*;

  logic        aw_held_ff;
  logic        w_held_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        aw_ok;
  logic        w_ok;

  assign awready = !aw_held_ff && !bvalid;
  assign wready  = !w_held_ff && !bvalid;
  assign aw_ok   = aw_held_ff || (awvalid && awready);
  assign w_ok    = w_held_ff || (wvalid && wready);
  assign wr_en   = aw_ok && w_ok && !bvalid;
  assign wr_addr = aw_held_ff ? aw_addr_ff : awaddr;
  assign wr_data = w_held_ff ? w_data_ff : wdata;
  assign wr_strb = w_held_ff ? w_strb_ff : wstrb;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  // ==========================================================
  // write channel
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else begin
      if (wr_en) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else begin
        if (awvalid && awready) begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= awaddr;
        end
        if (wvalid && wready) begin
          w_held_ff <= 1'b1;
          w_data_ff <= wdata;
          w_strb_ff <= wstrb;
        end
        if (bvalid && bready) begin
          bvalid <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // read channel
  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : psc_axil
`default_nettype wire

//--- design/psc_scan.sv
`timescale 1ns/1ps
`default_nettype none
module psc_scan #(
  parameter int INT_CYC   = psc_pkg::INT_PERIOD_CYC,
  parameter int SCAN_CYC  = psc_pkg::SCAN_CYC,
  parameter int STAT_CYC  = psc_pkg::STATUS_CYC,
  parameter int GROUP_CYC = psc_pkg::GROUP_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // panel pins
  output logic [3:0]       scan_line_outputs,
  input  wire logic [3:0]  scan_return_inputs,
  input  wire logic [3:0]  step_switch_inputs,
  output logic [3:0]       step_lamp_outputs,
  // sampled panel state
  output logic [3:0]       status_ff,
  output logic [15:0]      step_sw_ff,
  output logic [15:0]      ret_sw_ff,
  output logic [1:0]       line_idx_ff
);
  import psc_pkg::*;
  localparam int CW = $clog2(INT_CYC + 1);

  logic [CW-1:0] int_cnt_ff;
  logic [CW-1:0] seq_cnt_ff;
  logic          active_ff;
  logic          in_group_ff;
  logic          first_done_ff;
  logic          int_pulse;
  logic          nxt_group;
  logic          seq_end;

  assign int_pulse = int_cnt_ff == CW'(INT_CYC - 1);
  assign seq_end   = active_ff && seq_cnt_ff == CW'(SCAN_CYC - 1);
  assign nxt_group = active_ff && seq_cnt_ff >= CW'(STAT_CYC - 1)
                     && seq_cnt_ff < CW'(STAT_CYC + GROUP_CYC - 1);

  // ==========================================================
  // interrupt timer and scan sequence
  always_ff @(posedge clock) begin
    if (rst) begin
      int_cnt_ff <= '0;
    end else begin
      int_cnt_ff <= int_pulse ? '0 : int_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      seq_cnt_ff    <= '0;
      active_ff     <= 1'b0;
      line_idx_ff   <= 2'h0;
      first_done_ff <= 1'b0;
    end else if (int_pulse) begin
      seq_cnt_ff <= '0;
      active_ff  <= 1'b1;
    end else if (seq_end) begin
      active_ff     <= 1'b0;
      line_idx_ff   <= line_idx_ff + 2'h1;
      first_done_ff <= 1'b1;
    end else if (active_ff) begin
      seq_cnt_ff <= seq_cnt_ff + 1'b1;
    end
  end

  // ==========================================================
  // scan lines: all high for status, one low for a group
  always_ff @(posedge clock) begin
    if (rst) begin
      scan_line_outputs <= 4'hF;
      in_group_ff       <= 1'b0;
    end else begin
      in_group_ff       <= nxt_group;
      scan_line_outputs <= nxt_group ? ~(4'h1 << line_idx_ff)
                                     : 4'hF;
    end
  end

  // ==========================================================
  // sampling and lamps
  always_ff @(posedge clock) begin
    if (rst) begin
      status_ff  <= 4'h0;
      step_sw_ff <= 16'h0000;
      ret_sw_ff  <= 16'h0000;
    end else begin
      if (active_ff && seq_cnt_ff == CW'(STAT_CYC - 1)) begin
        status_ff <= scan_return_inputs;
      end
      if (in_group_ff && !nxt_group) begin
        step_sw_ff[line_idx_ff*4 +: 4] <= step_switch_inputs;
        ret_sw_ff[line_idx_ff*4 +: 4]  <= scan_return_inputs;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      step_lamp_outputs <= 4'h0;
    end else if (int_pulse) begin
      step_lamp_outputs <= 4'h0;
    end else if (in_group_ff && first_done_ff) begin
      step_lamp_outputs <= step_lamp_outputs | step_switch_inputs;
    end
  end

  // ==========================================================
  // checks
  status_high_a: assert property (@(posedge clock) disable iff (rst)
    active_ff && seq_cnt_ff > '0 && seq_cnt_ff < CW'(STAT_CYC)
    |-> scan_line_outputs == 4'hF)
    else $error("scan lines not all high in status phase");
  one_line_a: assert property (@(posedge clock) disable iff (rst)
    in_group_ff |-> scan_line_outputs == ~(4'h1 << line_idx_ff))
    else $error("group phase does not drive exactly one line low");
  line_advance_a: assert property (@(posedge clock) disable iff (rst)
    seq_end |=> line_idx_ff == $past(line_idx_ff) + 2'h1)
    else $error("scan line did not advance");
  lamp_hold_a: assert property (@(posedge clock) disable iff (rst)
    !$past(int_pulse) |-> (step_lamp_outputs & $past(step_lamp_outputs))
    == $past(step_lamp_outputs))
    else $error("lamp dropped before next interrupt");
  int_period_a: assert property (@(posedge clock) disable iff (rst)
    $rose(active_ff) |-> $past(int_cnt_ff) == CW'(INT_CYC - 1))
    else $error("scan began off the interrupt period");
endmodule : psc_scan
`default_nettype wire

//--- design/psc_top.sv
// Function
// - a panel scan starts on every interrupt, one each 1.9 ms.
// - each scan lasts about 600 us; the rest is left idle.
// - all four scan lines high for the first 150 us; status is sampled.
// - then one line low, advancing 0,1,2,3 on successive interrupts.
// - while a line is low, step and return inputs are sampled.
// - after the first scan, a closed step switch lights its lamp, latched until next interrupt.
// - the group reading phase lasts about 450 us.
// - each switch group is refreshed every fourth interrupt, 7.6 ms.
// - shared trigger pulses run continuously from reset, whatever state.
// - trigger pulse spacing equals the step period register, never shorter than the minimum period.
// - instrument bits share the ports, valid together with the trigger.
// - instrument phase carries one bit per voice plus an accent bit.
// - each voice gate is its instrument bit ANDed with the trigger.
// - address phase carries rhythm, step and bank numbers.
// - four 1Kx4 RAMs chosen by bank bits, decode only while enabled.
// - memory writes only while write control is low, else reads.
// - chip enable lasts 10 us; read data captured at its end, write data driven throughout.
`timescale 1ns/1ps
`default_nettype none
module psc_top #(
  parameter int INT_CYC   = psc_pkg::INT_PERIOD_CYC,
  parameter int SCAN_CYC  = psc_pkg::SCAN_CYC,
  parameter int STAT_CYC  = psc_pkg::STATUS_CYC,
  parameter int GROUP_CYC = SCAN_CYC - STAT_CYC,
  parameter int MEM_CYC   = psc_pkg::MEM_ACCESS_CYC,
  parameter int TRIG_CYC  = psc_pkg::TRIG_WIDTH_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // panel
  output logic [3:0]       scan_line_outputs,
  input  wire logic [3:0]  scan_return_inputs,
  input  wire logic [3:0]  step_switch_inputs,
  output logic [3:0]       step_lamp_outputs,
  // shared address and instrument ports
  output logic [3:0]       rhythm_port,
  output logic [3:0]       step_port,
  output logic [3:0]       bank_port,
  // pattern memory
  output logic             chip_enable_pulse_output_n,
  output logic             write_control_output_n,
  output logic [3:0]       ram_select_n,
  input  wire logic [3:0]  memory_data_port_i,
  output logic [3:0]       memory_data_port_o,
  output logic             memory_data_port_oe,
  // triggers
  output logic             trigger_output,
  output logic [10:0]      voice_gate_outputs,
  output logic             accent_gate_output
);
  import psc_pkg::*;
  localparam logic [31:0] MIN_PERIOD = 32'(TRIG_CYC + MEM_CYC + 2);
  localparam int          MW         = $clog2(MEM_CYC + 1);

  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [3:0]  status_ff;
  logic [15:0] step_sw_ff;
  logic [15:0] ret_sw_ff;
  logic [1:0]  line_idx_ff;
  logic [31:0] step_period_ff;
  logic [31:0] act_period_ff;
  logic [31:0] step_cnt_ff;
  logic [11:0] inst_ff;
  logic [11:0] mem_addr_ff;
  logic [3:0]  mem_wdata_ff;
  logic        mem_write_ff;
  logic        pending_ff;
  logic        access_ff;
  logic [MW-1:0] acc_cnt_ff;
  logic [3:0]  mem_rdata_ff;
  logic        go;
  logic        window_ok;
  logic        nxt_trig;
  logic [31:0] nxt_period;

  // ==========================================================
  // register bus and panel scanner
  psc_axil u_bus (
    .clock   (clock),   .rst     (rst),
    .awaddr  (awaddr),  .awvalid (awvalid), .awready (awready),
    .wdata   (wdata),   .wstrb   (wstrb),   .wvalid  (wvalid),
    .wready  (wready),  .bresp   (bresp),   .bvalid  (bvalid),
    .bready  (bready),  .araddr  (araddr),  .arvalid (arvalid),
    .arready (arready), .rdata   (rdata),   .rresp   (rresp),
    .rvalid  (rvalid),  .rready  (rready),  .wr_en   (wr_en),
    .wr_addr (wr_addr), .wr_data (wr_data), .wr_strb (wr_strb),
    .wr_err  (wr_err),  .rd_addr (rd_addr), .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  psc_scan #(
    .INT_CYC   (INT_CYC),
    .SCAN_CYC  (SCAN_CYC),
    .STAT_CYC  (STAT_CYC),
    .GROUP_CYC (GROUP_CYC)
  ) u_scan (
    .clock              (clock),
    .rst                (rst),
    .scan_line_outputs  (scan_line_outputs),
    .scan_return_inputs (scan_return_inputs),
    .step_switch_inputs (step_switch_inputs),
    .step_lamp_outputs  (step_lamp_outputs),
    .status_ff          (status_ff),
    .step_sw_ff         (step_sw_ff),
    .ret_sw_ff          (ret_sw_ff),
    .line_idx_ff        (line_idx_ff)
  );

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================
  // register writes
  always_comb begin
    unique case (wr_addr)
      REG_STEP_PERIOD, REG_INSTR, REG_MEM_ADDR, REG_MEM_CMD,
      REG_MEM_STAT, REG_PANEL, REG_STEP_SW, REG_RET_SW,
      REG_LAMPS: wr_err = 1'b0;
      default:   wr_err = 1'b1;
    endcase
  end

  assign go = wr_en && wr_addr == REG_MEM_CMD && wr_strb[0]
              && wr_data[CMD_GO_BIT] && !pending_ff && !access_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      step_period_ff <= STEP_PERIOD_RST;
      inst_ff        <= 12'h000;
      mem_addr_ff    <= 12'h000;
    end else if (wr_en) begin
      if (wr_addr == REG_STEP_PERIOD) begin
        step_period_ff <= merge(step_period_ff, wr_data, wr_strb);
      end
      if (wr_addr == REG_INSTR) begin
        inst_ff <= 12'(merge({20'h0_0000, inst_ff}, wr_data, wr_strb));
      end
      if (wr_addr == REG_MEM_ADDR) begin
        mem_addr_ff <= 12'(merge({20'h0_0000, mem_addr_ff},
                                 wr_data, wr_strb));
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mem_write_ff <= 1'b0;
      mem_wdata_ff <= 4'h0;
    end else if (go) begin
      mem_write_ff <= wr_data[CMD_WRITE_BIT];
      mem_wdata_ff <= wr_data[DATA_LSB +: 4];
    end
  end

  // ==========================================================
  // register reads
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (rd_addr)
      REG_STEP_PERIOD: rd_data = step_period_ff;
      REG_INSTR:       rd_data[11:0] = inst_ff;
      REG_MEM_ADDR:    rd_data[11:0] = mem_addr_ff;
      REG_MEM_CMD: begin
        rd_data[CMD_WRITE_BIT]  = mem_write_ff;
        rd_data[DATA_LSB +: 4]  = mem_wdata_ff;
      end
      REG_MEM_STAT: begin
        rd_data[0]             = pending_ff || access_ff;
        rd_data[DATA_LSB +: 4] = mem_rdata_ff;
      end
      REG_PANEL:   rd_data[5:0] = {line_idx_ff, status_ff};
      REG_STEP_SW: rd_data[15:0] = step_sw_ff;
      REG_RET_SW:  rd_data[15:0] = ret_sw_ff;
      REG_LAMPS:   rd_data[3:0] = step_lamp_outputs;
      default:     rd_err = 1'b1;
    endcase
  end

  // ==========================================================
  // shared trigger timebase
  assign nxt_period = step_period_ff < MIN_PERIOD ? MIN_PERIOD
                                                  : step_period_ff;
  assign nxt_trig   = step_cnt_ff < 32'(TRIG_CYC);

  always_ff @(posedge clock) begin
    if (rst) begin
      step_cnt_ff   <= 32'h0000_0000;
      act_period_ff <= MIN_PERIOD;
    end else if (step_cnt_ff >= act_period_ff - 32'h1) begin
      step_cnt_ff   <= 32'h0000_0000;
      act_period_ff <= nxt_period;
    end else begin
      step_cnt_ff <= step_cnt_ff + 32'h1;
    end
  end

  // port mux and voice gates
  always_ff @(posedge clock) begin
    if (rst) begin
      trigger_output     <= 1'b0;
      voice_gate_outputs <= 11'h000;
      accent_gate_output <= 1'b0;
      rhythm_port        <= 4'h0;
      step_port          <= 4'h0;
      bank_port          <= 4'h0;
    end else begin
      trigger_output     <= nxt_trig;
      voice_gate_outputs <= nxt_trig ? inst_ff[10:0] : 11'h000;
      accent_gate_output <= nxt_trig && inst_ff[11];
      if (nxt_trig) begin
        {step_port, bank_port, rhythm_port} <= inst_ff;
      end else begin
        bank_port   <= mem_addr_ff[11:8];
        step_port   <= mem_addr_ff[7:4];
        rhythm_port <= mem_addr_ff[3:0];
      end
    end
  end

  // ==========================================================
  // pattern memory access
  assign window_ok = step_cnt_ff >= 32'(TRIG_CYC)
                     && step_cnt_ff + 32'(MEM_CYC + 1) < act_period_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      pending_ff <= 1'b0;
      access_ff  <= 1'b0;
      acc_cnt_ff <= '0;
    end else if (pending_ff && window_ok) begin
      pending_ff <= 1'b0;
      access_ff  <= 1'b1;
      acc_cnt_ff <= '0;
    end else if (access_ff) begin
      if (acc_cnt_ff == MW'(MEM_CYC - 1)) begin
        access_ff <= 1'b0;
      end
      acc_cnt_ff <= acc_cnt_ff + 1'b1;
    end else if (go) begin
      pending_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mem_rdata_ff <= 4'h0;
    end else if (access_ff && !mem_write_ff
                 && acc_cnt_ff == MW'(MEM_CYC - 1)) begin
      mem_rdata_ff <= memory_data_port_i;
    end
  end

  assign chip_enable_pulse_output_n = !access_ff;
  assign write_control_output_n = !(access_ff && mem_write_ff);
  assign memory_data_port_o     = mem_wdata_ff;
  assign memory_data_port_oe    = access_ff && mem_write_ff;

  always_comb begin
    ram_select_n = 4'hF;
    if (access_ff) begin
      ram_select_n[bank_port[BANK_SEL_LSB +: 2]] = 1'b0;
    end
  end

  // ==========================================================
  // checks
  // first pulse after reset has no preceding wrap
  sequence trig_start_s;
    $rose(trigger_output) && !$past(rst, 2);
  endsequence
  sequence period_wrap_s;
    $past(step_cnt_ff) == 32'h0
    && $past(step_cnt_ff, 2) == $past(act_period_ff, 2) - 32'h1;
  endsequence

  trig_period_a: assert property (@(posedge clock) disable iff (rst)
    trig_start_s |-> period_wrap_s)
    else $error("trigger rose off the step period");
  gate_and_a: assert property (@(posedge clock) disable iff (rst)
    (voice_gate_outputs != 11'h000 || accent_gate_output)
    |-> trigger_output)
    else $error("voice gate fired without trigger");
  inst_mux_a: assert property (@(posedge clock) disable iff (rst)
    trigger_output && $stable(inst_ff)
    |-> {step_port, bank_port, rhythm_port} == $past(inst_ff))
    else $error("ports not carrying instrument bits in trigger");
  no_clash_a: assert property (@(posedge clock) disable iff (rst)
    !chip_enable_pulse_output_n |-> !trigger_output)
    else $error("memory access overlapped trigger");
  ce_length_a: assert property (@(posedge clock) disable iff (rst)
    $rose(chip_enable_pulse_output_n)
    |-> $past(acc_cnt_ff) == MW'(MEM_CYC - 1))
    else $error("chip enable pulse wrong length");
  write_ctl_a: assert property (@(posedge clock) disable iff (rst)
    !write_control_output_n
    |-> !chip_enable_pulse_output_n && memory_data_port_oe)
    else $error("write control low outside a write access");
  select_a: assert property (@(posedge clock) disable iff (rst)
    ram_select_n != 4'hF |-> !chip_enable_pulse_output_n
    && $countones(~ram_select_n) == 1)
    else $error("ram select outside chip enable");
endmodule : psc_top
`default_nettype wire

//--- test/psc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_panel_model (
  // panel
  input  wire logic [3:0]  sl,
  input  wire logic [15:0] sw,
  output logic [3:0]       stp,
  output logic [3:0]       ret,
  // memory
  input  wire logic        clock,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic [3:0]  sel_n,
  input  wire logic [9:0]  a,
  input  wire logic [3:0]  din,
  output logic [3:0]       dout
);
  logic [3:0] mem [4][1024];
  logic [3:0] last_ff = 4'h5;
  function automatic logic [1:0] low(input logic [3:0] v);
    low = 2'h0;
    for (int i = 0; i < 4; i++)
      if (!v[i]) low = i[1:0];
  endfunction : low
  // ==========================================
  // switch matrix, open step inputs read low, open returns read high
  assign stp = sl == 4'hF ? 4'h0 : sw[low(sl)*4+:4];
  assign ret = sl == 4'hF ? 4'hA : ~sw[low(sl)*4+:4];
  // ==========================================
  // four chips, unselected bus keeps toggling
  always @(posedge clock) begin
    if (!ce_n && !we_n) mem[low(sel_n)][a] <= din;
    last_ff <= dout;
  end
  assign dout = !ce_n && we_n ? mem[low(sel_n)][a] : ~last_ff;
endmodule : psc_panel_model
`default_nettype wire

//--- test/panel_scan_pattern_io_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module panel_scan_pattern_io_tb_top;
  import psc_pkg::*;
  logic        clock = 0, rst = 1, lt;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, awready, wready, bvalid, arready, rvalid;
  logic        ce_n, we_n, oe, trig, acc;
  logic [10:0] vg;
  logic [3:0]  wstrb = 4'hF, lamp;
  logic [1:0]  bresp, rresp, k;
  logic [3:0]  sl, ret, stp, rp, sp, bp, sel_n, mo, md, di, last;
  logic [15:0] sw = 0;
  logic [33:0] q [$];
  logic [31:0] mq [$];
  int          fail_count = 0, cmp_count = 0, ntrig = 0, n;
  assign di = oe ? mo : md;
  always #2.5 clock = ~clock;
  psc_top #(.INT_CYC(400), .SCAN_CYC(120), .STAT_CYC(30),
    .MEM_CYC(4), .TRIG_CYC(4)) i_psc_top (
    .clock, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready,
    .scan_line_outputs(sl), .scan_return_inputs(ret),
    .step_switch_inputs(stp), .step_lamp_outputs(lamp),
    .rhythm_port(rp), .step_port(sp), .bank_port(bp),
    .chip_enable_pulse_output_n(ce_n), .write_control_output_n(we_n),
    .ram_select_n(sel_n), .memory_data_port_i(di),
    .memory_data_port_o(mo), .memory_data_port_oe(oe),
    .trigger_output(trig), .voice_gate_outputs(vg),
    .accent_gate_output(acc));
  psc_panel_model i_psc_panel_model (.sl, .sw, .stp, .ret, .clock,
    .ce_n, .we_n, .sel_n, .a({bp[1:0], sp, rp}), .din(di), .dout(md));
  // ==========================================
  // checking and closing
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic limit(input int n);
    if (n >= 500) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : limit
  always @(posedge clock) begin
    if (rvalid && rready)
      chk({rresp, rdata & mq.pop_front()}, q.pop_front());
    last <= sl;
    lt <= trig;
    if (trig && !lt) ntrig <= ntrig + 1;
    if (rst) k <= 2'h0;
    else if (sl !== last && sl !== 4'hF) begin
      chk({30'h0, sl}, {30'h0, ~(4'h1 << k)});
      k <= k + 2'h1;
    end
  end
  // ==========================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] e);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 500; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    limit(n);
    chk({32'h0, bresp}, {32'h0, e});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e,
                    input logic [31:0] m);
    int n;
    q.push_back(e);
    mq.push_back(m);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 500; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    limit(n);
  endtask : rd
  task automatic wait_ce(input logic v);
    int n;
    for (n = 0; n < 500 && ce_n !== v; n++) @(posedge clock);
    limit(n);
  endtask : wait_ce
  task automatic rise(output int n);
    for (n = 0; n < 500 && !(trig && !lt); n++) @(posedge clock);
    limit(n);
  endtask : rise
  // ==========================================
  // scenarios
  initial begin
    void'($urandom(32'h140a));
    sw <= 16'($urandom());
    repeat (16) @(posedge clock);
    rst <= 0;
    wr(REG_STEP_PERIOD, 32'h28, RESP_OKAY);
    rd(REG_PANEL, 34'h0, 32'h30);
    chk({30'h0, sl}, 34'hF);
    chk({30'h0, lamp}, 34'h0);
    $display("test reset done");
    repeat (1800) @(posedge clock);
    rd(REG_STEP_SW, {18'h0, sw}, 32'hFFFF);
    rd(REG_RET_SW, {18'h0, ~sw}, 32'hFFFF);
    rd(REG_PANEL, 34'hA, 32'hF);
    chk({30'h0, lamp}, {30'h0, sw[15:12]});
    $display("test scan done");
    d = $urandom();
    wr(REG_INSTR, {20'h0, d[11:0]}, RESP_OKAY);
    @(posedge clock);
    rise(n);
    chk({23'h0, vg}, {23'h0, d[10:0]});
    chk({33'h0, acc}, {33'h0, d[11]});
    chk({22'h0, sp, bp, rp}, {22'h0, d[11:0]});
    @(posedge clock);
    rise(n);
    chk(34'(n + 1), 34'h28);
    $display("test trigger done");
    // all four chips written first, then read back
    for (int b = 0; b < 8; b++) begin
      wr(REG_MEM_ADDR, {20'h0, b[1:0], d[21:12]}, RESP_OKAY);
      wr(REG_MEM_CMD, b < 4 ? {24'h0, b[1:0], d[1:0], 4'h3} : 32'h1,
         RESP_OKAY);
      wait_ce(0);
      wait_ce(1);
      if (b >= 4)
        rd(REG_MEM_STAT, {26'h0, b[1:0], d[1:0], 4'h0}, 32'hF1);
    end
    $display("test memory done");
    wr(8'h40, 32'h0, RESP_SLVERR);
    rd(8'h40, {RESP_SLVERR, 32'h0}, 32'h0);
    chk({33'h0, ntrig > 1}, 34'h1);
    $display("test misc done");
    tally_and_finish();
  end
endmodule : panel_scan_pattern_io_tb_top
`default_nettype wire
